// ===== msrca_defines.vh
// Constants for the serial slave coil and register access block.
`ifndef MSRCA_DEFINES_VH
`define MSRCA_DEFINES_VH

`define MSRCA_FC_RD_COILS  8'h01
`define MSRCA_FC_RD_REGS   8'h03
`define MSRCA_FC_WR_COIL   8'h05
`define MSRCA_FC_WR_REG    8'h06
`define MSRCA_FC_WR_COILS  8'h0F
`define MSRCA_FC_WR_REGS   8'h10

`define MSRCA_EX_ADDR      8'h40
`define MSRCA_EX_LEN       8'h41
`define MSRCA_EX_VAL       8'h42
`define MSRCA_EX_FUNC      8'h43
`define MSRCA_EX_NONE      8'h00
`define MSRCA_ERR_FLAG     8'h80

`define MSRCA_ADDR_BCAST   8'h00
`define MSRCA_COIL_ON      16'hFF00
`define MSRCA_COIL_OFF     16'h0000

`define MSRCA_IX_SA        9'h000
`define MSRCA_IX_FC        9'h001
`define MSRCA_IX_F2        9'h002
`define MSRCA_IX_F3        9'h003
`define MSRCA_IX_F4        9'h004
`define MSRCA_IX_F5        9'h005
`define MSRCA_IX_BC        9'h006
`define MSRCA_IX_DATA      9'h007
`define MSRCA_IX_MAX       9'h1FF
`define MSRCA_LAST_FIXED   9'h005
`define MSRCA_LAST_MULTI   9'h006
`define MSRCA_EXC_LEN      9'h003
`define MSRCA_ECHO_LEN     9'h006
`define MSRCA_RD_HDR_LEN   9'h003

`define MSRCA_COIL_RST     1'b0
`define MSRCA_REG_RST      16'h0000

`endif

// ===== msrca_hregs.v
// Holding register file with one write port and one read port.
`timescale 1ns/1ps
`default_nettype none
`include "msrca_defines.vh"
module msrca_hregs #(
  parameter NREGS = 16,
  parameter RAW   = 4
) (
  input  wire            clk_i,
  input  wire            rst_i,
  input  wire            we_i,
  input  wire [RAW-1:0]  waddr_i,
  input  wire [15:0]     wdata_i,
  input  wire [RAW-1:0]  raddr_i,
  output wire [15:0]     rdata_o
);
  reg  [15:0] mem [0:NREGS-1];

  genvar e;
  generate
    for (e = 0; e < NREGS; e = e + 1) begin : g_ent
      always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          mem[e] <= `MSRCA_REG_RST;
        end else if (we_i && waddr_i == e) begin
          mem[e] <= wdata_i;
        end
      end
    end
  endgenerate

  // Reads past NREGS are not blocked here; the range check upstream only keeps their data out of replies.
  assign rdata_o = mem[raddr_i];
endmodule
`default_nettype wire

// ===== msrca_core.v
// Function-code handler for a serial slave with coils and holding registers.
`timescale 1ns/1ps
`default_nettype none
`include "msrca_defines.vh"
module msrca_core #(
  parameter NCOILS = 64,
  parameter NREGS  = 16,
  parameter RAW    = 4
) (
  input  wire              clk_i,
  input  wire              rst_i,
  input  wire [7:0]        node_addr_i,
  input  wire              rx_valid_i,
  input  wire [7:0]        rx_byte_i,
  input  wire              rx_last_i,
  output wire              rx_ready_o,
  output wire              tx_valid_o,
  output reg  [7:0]        tx_byte_o,
  output wire              tx_last_o,
  input  wire              tx_ready_i,
  output wire [NCOILS-1:0] coils_o,
  output reg               hr_wr_o,
  output reg  [15:0]       hr_addr_o,
  output reg  [15:0]       hr_data_o
);
  localparam [2:0] S_RX   = 3'h1;
  localparam [2:0] S_EVAL = 3'h2;
  localparam [2:0] S_TX   = 3'h4;
  localparam [16:0] NC17  = NCOILS;
  localparam [16:0] NR17  = NREGS;

  reg  [2:0]        state;
  reg  [8:0]        ix;
  reg  [8:0]        last_ix;
  reg  [7:0]        sa;
  reg  [7:0]        fc;
  reg  [7:0]        f2;
  reg  [7:0]        f3;
  reg  [7:0]        f4;
  reg  [7:0]        f5;
  reg  [7:0]        bc;
  reg  [7:0]        hi_b;
  reg  [7:0]        exc;
  reg  [7:0]        addr_s1;
  reg  [7:0]        addr_s2;
  reg  [8:0]        tix;
  reg  [8:0]        tlen;
  reg  [NCOILS-1:0] coils;
  wire [NCOILS-1:0] next_coils;
  reg  [7:0]        next_byte;
  reg  [7:0]        next_exc;

  // Query field decode.
  wire [15:0] start = {f2, f3};
  wire [15:0] qraw  = {f4, f5};
  wire is_rc = (fc == `MSRCA_FC_RD_COILS);
  wire is_rr = (fc == `MSRCA_FC_RD_REGS);
  wire is_c1 = (fc == `MSRCA_FC_WR_COIL);
  wire is_r1 = (fc == `MSRCA_FC_WR_REG);
  wire is_mc = (fc == `MSRCA_FC_WR_COILS);
  wire is_mr = (fc == `MSRCA_FC_WR_REGS);
  wire fc_ok = is_rc | is_rr | is_c1 | is_r1 | is_mc | is_mr;
  wire rd    = is_rc | is_rr;
  wire multi = is_mc | is_mr;
  wire coilsp = is_rc | is_c1 | is_mc;
  wire [15:0] qty = (is_c1 | is_r1) ? 16'h0001 : qraw;

  // Zero-based wire address: start plus count must stay inside the space.
  wire [16:0] endp    = {1'b0, start} + {1'b0, qty};
  wire [16:0] lim     = coilsp ? NC17 : NR17;
  wire        addr_ok = (endp <= lim);
  wire [16:0] q7      = {1'b0, qty} + 17'h00007;
  wire [8:0]  cbytes  = q7[11:3];
  wire [8:0]  rbytes  = {qty[7:0], 1'b0};
  wire [8:0]  dbytes  = coilsp ? cbytes : rbytes;
  wire val_ok = !is_c1 || qraw == `MSRCA_COIL_OFF ||
                qraw == `MSRCA_COIL_ON;
  wire bc_ok  = !multi || ({1'b0, bc} == dbytes);
  wire qty_ok = (qty != 16'h0000);
  wire hdr_ok = fc_ok & addr_ok & qty_ok & bc_ok & val_ok;
  wire [8:0] exp_last = multi ? (`MSRCA_LAST_MULTI + {1'b0, bc})
                              : `MSRCA_LAST_FIXED;
  wire len_ok = (last_ix == exp_last);

  wire bcast = (sa == `MSRCA_ADDR_BCAST);
  // The address pins are static, so a two-stage synchroniser on the whole
  // byte is safe; a skewed sample can only appear while the pins move.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_s1 <= 8'h00;
      addr_s2 <= 8'h00;
    end else begin
      addr_s1 <= node_addr_i;
      addr_s2 <= addr_s1;
    end
  end
  wire mine  = (sa == addr_s2) & !bcast;
  wire ours  = mine | bcast;

  assign rx_ready_o = state[0];
  wire take = state[0] & rx_valid_i;

  // Multi writes act on each data byte as it arrives, once the header
  // is known good, so no frame buffer is needed.  A frame that turns out
  // too long still keeps the writes made from its leading bytes.
  wire [8:0] d    = ix - `MSRCA_IX_DATA;
  wire dstb = take & multi & ours & hdr_ok &
              (ix >= `MSRCA_IX_DATA) & (d < {1'b0, bc});
  wire cw_m = dstb & is_mc;
  wire rw_m = dstb & is_mr & d[0];

  // Single writes wait for the whole frame to be checked.
  wire ok_all = state[1] & ours & fc_ok & len_ok & hdr_ok;
  wire cw_1 = ok_all & is_c1;
  wire rw_1 = ok_all & is_r1;

  // Holding register write path, also passed out as a strobe.
  wire        we    = rw_m | rw_1;
  wire [15:0] waddr = rw_1 ? start : start + {8'h00, d[8:1]};
  wire [15:0] wdata = rw_1 ? qraw : {hi_b, rx_byte_i};

  // Transmit byte selection.
  wire [8:0]  nidx = state[1] ? 9'h000 : tix + 9'h001;
  wire [8:0]  kb   = nidx - `MSRCA_RD_HDR_LEN;
  wire [15:0] raddr = start + {8'h00, kb[8:1]};
  wire [15:0] rdata;
  wire [7:0]  cbyte;

  msrca_hregs #(
    .NREGS (NREGS),
    .RAW   (RAW)
  ) u_hregs (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .we_i    (we),
    .waddr_i (waddr[RAW-1:0]),
    .wdata_i (wdata),
    .raddr_i (raddr[RAW-1:0]),
    .rdata_o (rdata)
  );

  genvar j;
  genvar b;
  generate
    for (j = 0; j < NCOILS; j = j + 1) begin : g_coil
      localparam [15:0] J16 = j;
      wire [15:0] off   = J16 - start;
      wire        hit_m = cw_m & (off < qty) &
                          (off[15:3] == {4'h0, d});
      wire        hit_1 = cw_1 & (off == 16'h0000);
      assign next_coils[j] = hit_1 ? (f4 == 8'hFF) :
                             hit_m ? rx_byte_i[off[2:0]] :
                             coils[j];
    end
    for (b = 0; b < 8; b = b + 1) begin : g_cbit
      localparam [15:0] B16 = b;
      wire [15:0]       rel = {4'h0, kb, 3'h0} + B16;
      wire [NCOILS-1:0] sh  = coils >> (start + rel);
      // Bits past the requested count read as zero.
      assign cbyte[b] = (rel < qty) ? sh[0] : 1'b0;
    end
  endgenerate

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      coils <= {NCOILS{`MSRCA_COIL_RST}};
    end else begin
      coils <= next_coils;
    end
  end
  assign coils_o = coils;

  // Exception selection, in order of precedence.
  always @* begin
    if (!fc_ok) begin
      next_exc = `MSRCA_EX_FUNC;
    end else if (!len_ok) begin
      next_exc = `MSRCA_EX_LEN;
    end else if (!(qty_ok & bc_ok & val_ok)) begin
      next_exc = `MSRCA_EX_VAL;
    end else if (!addr_ok) begin
      next_exc = `MSRCA_EX_ADDR;
    end else begin
      next_exc = `MSRCA_EX_NONE;
    end
  end

  always @* begin
    next_byte = 8'h00;
    if (nidx == `MSRCA_IX_SA) begin
      next_byte = sa;
    end else if (exc != `MSRCA_EX_NONE) begin
      if (nidx == `MSRCA_IX_FC) begin
        next_byte = fc | `MSRCA_ERR_FLAG;
      end else begin
        next_byte = exc;
      end
    end else if (nidx == `MSRCA_IX_FC) begin
      next_byte = fc;
    end else if (rd) begin
      if (nidx == `MSRCA_IX_F2) begin
        next_byte = dbytes[7:0];
      end else if (is_rc) begin
        next_byte = cbyte;
      end else if (kb[0]) begin
        next_byte = rdata[7:0];
      end else begin
        next_byte = rdata[15:8];
      end
    end else begin
      case (nidx)
        `MSRCA_IX_F2: begin
          next_byte = f2;
        end
        `MSRCA_IX_F3: begin
          next_byte = f3;
        end
        `MSRCA_IX_F4: begin
          next_byte = f4;
        end
        default: begin
          next_byte = f5;
        end
      endcase
    end
  end

  assign tx_valid_o = state[2];
  assign tx_last_o  = state[2] & (tix == tlen - 9'h001);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hr_wr_o   <= 1'b0;
      hr_addr_o <= 16'h0000;
      hr_data_o <= 16'h0000;
    end else begin
      hr_wr_o <= we;
      if (we) begin
        hr_addr_o <= waddr;
        hr_data_o <= wdata;
      end
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state     <= S_RX;
      ix        <= 9'h000;
      last_ix   <= 9'h000;
      sa        <= 8'h00;
      fc        <= 8'h00;
      f2        <= 8'h00;
      f3        <= 8'h00;
      f4        <= 8'h00;
      f5        <= 8'h00;
      bc        <= 8'h00;
      hi_b      <= 8'h00;
      exc       <= 8'h00;
      tix       <= 9'h000;
      tlen      <= 9'h000;
      tx_byte_o <= 8'h00;
    end else begin
      case (state)
        S_RX: begin
          if (take) begin
            if (ix != `MSRCA_IX_MAX) begin
              ix <= ix + 9'h001;
            end
            case (ix)
              `MSRCA_IX_SA: begin
                sa <= rx_byte_i;
                fc <= 8'h00;
              end
              `MSRCA_IX_FC: begin
                fc <= rx_byte_i;
              end
              `MSRCA_IX_F2: begin
                f2 <= rx_byte_i;
              end
              `MSRCA_IX_F3: begin
                f3 <= rx_byte_i;
              end
              `MSRCA_IX_F4: begin
                f4 <= rx_byte_i;
              end
              `MSRCA_IX_F5: begin
                f5 <= rx_byte_i;
              end
              `MSRCA_IX_BC: begin
                bc <= rx_byte_i;
              end
              default: begin
                if (!d[0]) begin
                  hi_b <= rx_byte_i;
                end
              end
            endcase
            if (rx_last_i) begin
              last_ix <= ix;
              ix      <= 9'h000;
              state   <= S_EVAL;
            end
          end
        end
        S_EVAL: begin
          exc <= next_exc;
          tix <= 9'h000;
          if (rd) begin
            tlen <= `MSRCA_RD_HDR_LEN + dbytes;
          end else begin
            tlen <= `MSRCA_ECHO_LEN;
          end
          if (next_exc != `MSRCA_EX_NONE) begin
            tlen <= `MSRCA_EXC_LEN;
          end
          tx_byte_o <= next_byte;
          // A broadcast never answers, which keeps slaves off each other.
          if (!mine) begin
            state <= S_RX;
          end else begin
            state <= S_TX;
          end
        end
        S_TX: begin
          if (tx_ready_i) begin
            if (tix == tlen - 9'h001) begin
              state <= S_RX;
            end else begin
              tix       <= tix + 9'h001;
              tx_byte_o <= next_byte;
            end
          end
        end
        default: begin
          state <= S_RX;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== msrca_core_sva.sv
// Assertion checker for the coil and register access core.
`timescale 1ns/1ps
`default_nettype none
module msrca_core_sva #(
  parameter NCOILS = 64
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic [7:0]        node_addr_i,
  input wire logic              rx_valid_i,
  input wire logic [7:0]        rx_byte_i,
  input wire logic              rx_last_i,
  input wire logic              rx_ready_o,
  input wire logic              tx_valid_o,
  input wire logic [7:0]        tx_byte_o,
  input wire logic              tx_last_o,
  input wire logic              tx_ready_i,
  input wire logic [NCOILS-1:0] coils_o,
  input wire logic              hr_wr_o,
  input wire logic [15:0]       hr_addr_o,
  input wire logic [15:0]       hr_data_o
);
  logic [8:0]  rx_n;
  logic [8:0]  tx_n;
  logic [7:0]  q_sa;
  logic [7:0]  q_fc;
  logic [15:0] q_qty;
  logic        t_err;
  wire         rx_take = rx_valid_i && rx_ready_o;
  wire         tx_take = tx_valid_o && tx_ready_i;
  wire  [7:0]  sa_now = (rx_n == 9'h000) ? rx_byte_i : q_sa;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_n <= 9'h000;
      tx_n <= 9'h000;
      q_sa <= 8'h00;
      q_fc <= 8'h00;
      q_qty <= 16'h0000;
      t_err <= 1'b0;
    end else begin
      if (rx_take) begin
        rx_n <= rx_last_i ? 9'h000 : rx_n + 9'h001;
        if (rx_n == 9'h000) q_sa <= rx_byte_i;
        if (rx_n == 9'h001) q_fc <= rx_byte_i;
        if (rx_n == 9'h004) q_qty[15:8] <= rx_byte_i;
        if (rx_n == 9'h005) q_qty[7:0] <= rx_byte_i;
      end
      if (tx_take) begin
        tx_n <= tx_last_o ? 9'h000 : tx_n + 9'h001;
        if (tx_n == 9'h001) t_err <= tx_byte_o[7];
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence frame_end;
    rx_take && rx_last_i;
  endsequence
  sequence reply_gap;
    !tx_valid_o ##1 tx_valid_o;
  endsequence
  a_own_reply: assert property (
    frame_end ##0 (sa_now == node_addr_i) |=> reply_gap)
    else $error("own frame not answered two cycles later");
  a_foreign_quiet: assert property (
    frame_end ##0 (sa_now != node_addr_i) |=> !tx_valid_o [*4])
    else $error("reply to broadcast or foreign frame");
  a_hold_reply: assert property (
    tx_valid_o && !tx_ready_i |=>
      tx_valid_o && $stable(tx_byte_o) && $stable(tx_last_o))
    else $error("reply byte changed while stalled");
  a_reply_addr: assert property (
    tx_valid_o && tx_n == 9'h000 |-> tx_byte_o == node_addr_i)
    else $error("reply address wrong");
  a_reply_func: assert property (
    tx_valid_o && tx_n == 9'h001 |->
      tx_byte_o == q_fc || tx_byte_o == (q_fc | 8'h80))
    else $error("reply function code wrong");
  a_exc_code: assert property (
    tx_valid_o && tx_n == 9'h002 && t_err |->
      tx_last_o && tx_byte_o inside {[8'h40:8'h43]})
    else $error("exception reply malformed");
  a_coil_count: assert property (
    tx_valid_o && tx_n == 9'h002 && !t_err && q_fc == 8'h01 |->
      {8'h00, tx_byte_o} == ((q_qty + 16'h0007) >> 3))
    else $error("coil byte count wrong");
  a_reg_count: assert property (
    tx_valid_o && tx_n == 9'h002 && !t_err && q_fc == 8'h03 |->
      {8'h00, tx_byte_o} == (q_qty << 1))
    else $error("register byte count wrong");
  a_write_first: assert property (
    tx_valid_o && (hr_wr_o || !$stable(coils_o)) |->
      tx_n == 9'h000 && !$past(tx_valid_o))
    else $error("write seen after reply started");
  a_wr_pulse: assert property (
    hr_wr_o |=> !hr_wr_o)
    else $error("write strobe longer than one cycle");
endmodule
bind msrca_core msrca_core_sva #(.NCOILS(NCOILS)) u_sva (.*);
`default_nettype wire

// ===== msrca_master.sv
// Bus master model that sends queries and collects replies.
`timescale 1ns/1ps
`default_nettype none
module msrca_master (
  input  wire logic       clk_i,
  output var  logic       q_valid_o,
  output var  logic [7:0] q_byte_o,
  output var  logic       q_last_o,
  input  wire logic       q_ready_i,
  input  wire logic       r_valid_i,
  input  wire logic [7:0] r_byte_i,
  input  wire logic       r_last_i,
  output var  logic       r_ready_o
);
  logic [7:0] q [0:15];
  logic [7:0] r [0:15];
  int         rn = 0;
  int         lastn = 0;
  bit         slow = 1'b0;
  initial begin
    q_valid_o = 1'b0;
    q_byte_o = 8'h00;
    q_last_o = 1'b0;
    r_ready_o = 1'b1;
  end
  // Fields go big endian; addresses are zero-based on the wire.
  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      q_byte_o <= q[i];
      q_last_o <= (i == n - 1);
      q_valid_o <= 1'b1;
      @(posedge clk_i);
      while (!q_ready_i) @(posedge clk_i);
    end
    q_valid_o <= 1'b0;
    q_last_o <= 1'b0;
    // A released line must not keep looking like valid data.
    q_byte_o <= ~q_byte_o;
  endtask
  // A slow sink stalls every other cycle so held reply bytes are exercised.
  always @(posedge clk_i) begin
    if (r_valid_i && r_ready_o) begin
      r[rn[3:0]] <= r_byte_i;
      rn <= rn + 1;
      if (r_last_i) lastn <= rn;
    end
    r_ready_o <= slow ? !r_ready_o : 1'b1;
  end
endmodule
`default_nettype wire

// ===== msrca_core_tb_top.sv
// Self-checking testbench for the coil and register access core.
`timescale 1ns/1ps
`default_nettype none
module msrca_core_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  node_addr_i = 8'h01;
  wire         rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
  wire         hr_wr;
  wire  [7:0]  rx_byte, tx_byte;
  wire  [63:0] coils;
  wire  [15:0] hr_addr, hr_data;
  int          n_errors = 0;
  int          checks_done = 0;
  logic [7:0]  ex [0:15];
  always #25 clk_i = ~clk_i;
  msrca_core #(.NCOILS(64), .NREGS(16), .RAW(4)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .node_addr_i(node_addr_i),
    .rx_valid_i(rx_valid), .rx_byte_i(rx_byte), .rx_last_i(rx_last),
    .rx_ready_o(rx_ready), .tx_valid_o(tx_valid), .tx_byte_o(tx_byte),
    .tx_last_o(tx_last), .tx_ready_i(tx_ready), .coils_o(coils),
    .hr_wr_o(hr_wr), .hr_addr_o(hr_addr), .hr_data_o(hr_data));
  msrca_master m (
    .clk_i(clk_i), .q_valid_o(rx_valid), .q_byte_o(rx_byte),
    .q_last_o(rx_last), .q_ready_i(rx_ready), .r_valid_i(tx_valid),
    .r_byte_i(tx_byte), .r_last_i(tx_last), .r_ready_o(tx_ready));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string what);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic run(input logic [87:0] qv, input int qn,
                     input logic [87:0] xv, input int xn);
    for (int i = 0; i < qn; i++) m.q[i] = qv[8*(qn-1-i) +: 8];
    for (int i = 0; i < xn; i++) ex[i] = xv[8*(xn-1-i) +: 8];
    m.rn = 0;
    m.send(qn);
    repeat (6) @(posedge clk_i);
    for (int i = 0; i < 60 && !rx_ready; i++) @(posedge clk_i);
    chk(m.rn[15:0], xn[15:0], "reply length");
    for (int i = 0; i < xn; i++) chk(m.r[i], ex[i], "reply byte");
    if (xn > 0) chk(m.lastn[15:0], xn[15:0] - 1, "last flag");
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    complete_run;
  end
  task automatic t_coil_single;
    run(88'h01_05_00_03_FF_00, 6, 88'h01_05_00_03_FF_00, 6);
    chk({15'h0000, coils[3]}, 16'h0001, "coil 3");
  endtask
  task automatic t_coil_bcast;
    run(88'h00_0F_00_08_00_0A_02_A5_03, 9, 88'h0, 0);
    chk(coils[17:2], 16'hE942, "broadcast coils");
  endtask
  task automatic t_coil_multi;
    run(88'h01_0F_00_10_00_04_01_0F, 8, 88'h01_0F_00_10_00_04, 6);
    chk({12'h000, coils[19:16]}, 16'h000F, "coil range");
  endtask
  // A stalling sink makes the core hold each reply byte.
  task automatic t_coil_read;
    m.slow = 1'b1;
    run(88'h01_01_00_02_00_0A, 6, 88'h01_01_02_42_01, 5);
    m.slow = 1'b0;
  endtask
  task automatic t_reg_single;
    run(88'h01_06_00_02_12_34, 6, 88'h01_06_00_02_12_34, 6);
    chk(hr_addr, 16'h0002, "reg address");
    chk(hr_data, 16'h1234, "reg value");
  endtask
  task automatic t_reg_bcast;
    run(88'h00_10_00_03_00_02_04_AB_CD_00_E2, 11, 88'h0, 0);
    chk(hr_addr, 16'h0004, "last reg address");
    chk(hr_data, 16'h00E2, "last reg value");
  endtask
  task automatic t_reg_multi;
    run(88'h01_10_00_05_00_01_02_55_AA, 9, 88'h01_10_00_05_00_01, 6);
    chk(hr_data, 16'h55AA, "multi reg value");
  endtask
  task automatic t_reg_read;
    run(88'h01_03_00_02_00_04, 6, 88'h01_03_08_12_34_AB_CD_00_E2_55_AA,
        11);
  endtask
  task automatic t_refused;
    run(88'h00_03_00_00_00_01, 6, 88'h0, 0);
    run(88'h07_06_00_00_55_55, 6, 88'h0, 0);
    chk(hr_addr, 16'h0005, "ignored write");
    chk(hr_data, 16'h55AA, "ignored value");
  endtask
  task automatic t_exceptions;
    run(88'h01_07_00_00_00_01, 6, 88'h01_87_43, 3);
    run(88'h01_05_00_00_FF, 5, 88'h01_85_41, 3);
    run(88'h01_05_00_00_12_34, 6, 88'h01_85_42, 3);
    run(88'h01_03_00_10_00_01, 6, 88'h01_83_40, 3);
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({hr_wr, tx_valid, rx_ready, coils[12:0]}, 16'h2000, "reset");
    t_coil_single;
    t_coil_bcast;
    t_coil_multi;
    t_coil_read;
    t_reg_single;
    t_reg_bcast;
    t_reg_multi;
    t_reg_read;
    t_refused;
    t_exceptions;
    complete_run;
  end
endmodule
`default_nettype wire
